// [hdl/nvc_ctrl.sv]
// Nonvolatile storage control: commit sequencer, program cycle, CRC,
// and upper memory pointer. Register port comes from the serial slave.
// Assumes array, config-register and SRAM ports share mclk.
//
// Operation
// - Writing regs-to-SRAM bit starts copy; bit clears when copy ends.
// - Copy lands in SRAM page chosen by destination page select.
// - CRC fail flag sets on mismatch during EEPROM load; read only.
// - Auto CRC enable, reset one, makes program cycle compute CRC.
// - EEPROM loads into registers after reset and on commit bit.
// - Register reads are not answered during an EEPROM load.
// - EEPROM load only advances while always-on clock is active.
// - Busy flag reads one during whole erase/program; array blocked.
// - Program start acts only after previous transaction wrote key.
// - Erase/program cycle lasts about 230 ms.
// - Live CRC register shows CRC accumulated over EEPROM read.
// - Pointer high register holds four pointer bits, top reserved.
// - Pointer gives start; EEPROM and SRAM use nine bits, ROM twelve.
// - Program cycle counter increments per cycle, saturates at 255.
// - Data port reads start at pointer and advance afterwards.
`timescale 1ns/1ps
module nvc_ctrl #(
  parameter int NBYTES = 16,
  parameter int PAGES = 4,
  parameter int PROG_CYCLES = nvc_pkg::PROG_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic txn_end,
  input wire logic unlock_key_ok,
  input wire logic [7:0] mem_ptr_low,
  input wire logic [$clog2(PAGES)-1:0] sram_dest_page_sel,
  input wire logic aux_clk_active,
  output logic [11:0] memory_start_pointer,
  output logic [8:0] ee_rd_addr,
  output logic ee_rd_en,
  input wire logic [7:0] ee_rdata,
  output logic ee_access_block,
  output logic ee_prog_start,
  output logic ee_prog_crc_en,
  output logic cfg_wr,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  output logic sram_wr,
  output logic [8:0] sram_addr,
  output logic [7:0] sram_wdata,
  output logic [7:0] program_cycle_count
);

  localparam int IW = $clog2(NBYTES);
  localparam int PW = $clog2(PAGES);

  nvc_pkg::nvc_state_t st;
  logic [IW-1:0] idx;
  logic phase;
  logic boot_pend;
  logic load_req, store_req, prog_req;
  logic auto_crc, crc_fail;
  logic [7:0] live_crc;
  logic [3:0] ptr_high;
  logic key_in_txn, armed;
  logic aux_s1, aux_ok;
  logic tmr_busy, tmr_done;
  logic wr_ctl;

  assign wr_ctl = reg_wr && (reg_addr == nvc_pkg::ADDR_CTL_STAT);

  // CRC-8 step over one byte, MSB first
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ nvc_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Always-on clock status, two-flop synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aux_s1 <= 1'b0;
      aux_ok <= 1'b0;
    end else begin
      aux_s1 <= aux_clk_active;
      aux_ok <= aux_s1;
    end
  end

  // ----------------------------------------------------------------------
  // Unlock tracking across serial transactions
  // ----------------------------------------------------------------------
  // key must be in previous transaction
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      key_in_txn <= 1'b0;
      armed <= 1'b0;
    end else if (txn_end) begin
      armed <= key_in_txn || unlock_key_ok;
      key_in_txn <= 1'b0;
    end else if (unlock_key_ok) begin
      key_in_txn <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Control bits; requests stay set until the sequencer takes them
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      auto_crc <= nvc_pkg::AUTO_CRC_RST;
      load_req <= 1'b0;
      store_req <= 1'b0;
      prog_req <= 1'b0;
      ptr_high <= nvc_pkg::PTR_HIGH_RST;
    end else begin
      if (reg_wr && reg_addr == nvc_pkg::ADDR_PTR_HIGH) begin
        ptr_high <= reg_wdata[3:0];
      end
      if (wr_ctl) begin
        auto_crc <= reg_wdata[nvc_pkg::BIT_AUTO_CRC];
      end
      if (wr_ctl && reg_wdata[nvc_pkg::BIT_EE_TO_REGS]) begin
        load_req <= 1'b1;
      end else if (st == nvc_pkg::ST_IDLE && !tmr_busy) begin
        load_req <= 1'b0;
      end
      if (wr_ctl && reg_wdata[nvc_pkg::BIT_REGS_TO_SRAM]) begin
        store_req <= 1'b1;
      end else if (st == nvc_pkg::ST_IDLE && !tmr_busy && !load_req &&
                   !boot_pend) begin
        store_req <= 1'b0;
      end
      if (wr_ctl && reg_wdata[nvc_pkg::BIT_PROG] && armed) begin
        prog_req <= 1'b1;
      end else if (st == nvc_pkg::ST_PROG) begin
        prog_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer: load after reset, loads, copies and program launch
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= nvc_pkg::ST_IDLE;
      boot_pend <= 1'b1;
      idx <= '0;
      phase <= 1'b0;
      live_crc <= nvc_pkg::LIVE_CRC_RST;
      crc_fail <= 1'b0;
      ee_rd_en <= 1'b0;
      ee_rd_addr <= '0;
      cfg_wr <= 1'b0;
      cfg_addr <= '0;
      cfg_wdata <= '0;
      sram_wr <= 1'b0;
      sram_addr <= '0;
      sram_wdata <= '0;
      ee_prog_start <= 1'b0;
      ee_prog_crc_en <= 1'b0;
    end else begin
      ee_rd_en <= 1'b0;
      cfg_wr <= 1'b0;
      sram_wr <= 1'b0;
      ee_prog_start <= 1'b0;
      unique case (st)
        nvc_pkg::ST_IDLE: begin
          idx <= '0;
          phase <= 1'b0;
          // nothing starts while busy; a load or copy taken while ee_prog_start is high still runs into busy
          if (!tmr_busy) begin
            if (boot_pend || load_req) begin
              st <= nvc_pkg::ST_LOAD;
              boot_pend <= 1'b0;
              live_crc <= nvc_pkg::LIVE_CRC_RST;
            end else if (store_req) begin
              st <= nvc_pkg::ST_STORE;
            end else if (prog_req) begin
              st <= nvc_pkg::ST_PROG;
            end
          end
        end
        nvc_pkg::ST_LOAD: begin
          // stall while always-on clock is off
          if (aux_ok && !phase) begin
            ee_rd_en <= 1'b1;
            ee_rd_addr <= 9'(idx);
            phase <= 1'b1;
          end else if (aux_ok && phase) begin
            phase <= 1'b0;
            if (idx == IW'(NBYTES - 1)) begin
              // last byte holds the stored CRC
              if (ee_rdata != live_crc) begin
                crc_fail <= 1'b1;
              end
              st <= nvc_pkg::ST_IDLE;
            end else begin
              live_crc <= crc_step(live_crc, ee_rdata);
              cfg_wr <= 1'b1;
              cfg_addr <= 8'(idx);
              cfg_wdata <= ee_rdata;
              idx <= idx + 1'b1;
            end
          end
        end
        nvc_pkg::ST_STORE: begin
          if (!phase) begin
            cfg_addr <= 8'(idx);
            phase <= 1'b1;
          end else begin
            sram_wr <= 1'b1;
            sram_addr <= 9'({sram_dest_page_sel, idx});
            sram_wdata <= cfg_rdata;
            phase <= 1'b0;
            idx <= idx + 1'b1;
            if (idx == IW'(NBYTES - 1)) begin
              st <= nvc_pkg::ST_IDLE;
            end
          end
        end
        nvc_pkg::ST_PROG: begin
          ee_prog_start <= 1'b1;
          // CRC byte generated by the array controller
          ee_prog_crc_en <= auto_crc;
          st <= nvc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  nvc_prog_timer #(
    .CYCLES(PROG_CYCLES),
    .CW(32)
  ) u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .start(ee_prog_start),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------------
  // Program counter, pointer and array blocking outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      program_cycle_count <= '0;
      memory_start_pointer <= '0;
      ee_access_block <= 1'b0;
    end else begin
      if (tmr_done && program_cycle_count != nvc_pkg::COUNT_MAX) begin
        program_cycle_count <= program_cycle_count + 1'b1;
      end
      // data port reads begin at this pointer
      memory_start_pointer <= {ptr_high, mem_ptr_low};
      ee_access_block <= tmr_busy || ee_prog_start;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd && st != nvc_pkg::ST_LOAD;
      if (reg_rd && st != nvc_pkg::ST_LOAD) begin
        unique case (reg_addr)
          nvc_pkg::ADDR_CTL_STAT: reg_rdata <= {1'b0,
            store_req || st == nvc_pkg::ST_STORE, crc_fail, auto_crc,
            load_req || boot_pend, tmr_busy, 1'b0, prog_req};
          nvc_pkg::ADDR_LIVE_CRC: reg_rdata <= live_crc;
          nvc_pkg::ADDR_PTR_HIGH: reg_rdata <= {4'h0, ptr_high};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_NO_READ_IN_LOAD: assert property (@(posedge mclk) disable iff (!rstn)
    st == nvc_pkg::ST_LOAD |=> !reg_rd_valid)
    else $error("read answered during load");
  AST_LOAD_NEEDS_AUX: assert property (@(posedge mclk) disable iff (!rstn)
    (st == nvc_pkg::ST_LOAD && !aux_ok) |=> !ee_rd_en && !cfg_wr)
    else $error("load advanced without always-on clock");
  AST_BUSY_HOLDS: assert property (@(posedge mclk) disable iff (!rstn)
    ee_prog_start |=> tmr_busy [*8])
    else $error("busy dropped early");
  AST_NO_ARRAY_WHEN_BUSY: assert property (@(posedge mclk)
    disable iff (!rstn) tmr_busy |-> !ee_rd_en && !sram_wr)
    else $error("array accessed while busy");
  AST_PROG_NEEDS_KEY: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(prog_req) |-> $past(armed))
    else $error("program launched without key");
  AST_COUNT_SAT: assert property (@(posedge mclk) disable iff (!rstn)
    program_cycle_count == 8'hff |=> program_cycle_count == 8'hff)
    else $error("count wrapped");
  AST_COUNT_INC: assert property (@(posedge mclk) disable iff (!rstn)
    (tmr_done && program_cycle_count < 8'hff) |=>
    program_cycle_count == $past(program_cycle_count) + 8'h01)
    else $error("count missed increment");
  AST_PTR_HIGH_NIB: assert property (@(posedge mclk) disable iff (!rstn)
    (reg_wr && reg_addr == nvc_pkg::ADDR_PTR_HIGH) |=>
    ##1 memory_start_pointer[11:8] == $past(reg_wdata[3:0], 2))
    else $error("pointer high not captured");
  AST_SRAM_PAGE: assert property (@(posedge mclk) disable iff (!rstn)
    sram_wr |-> sram_addr[IW+PW-1:IW] == $past(sram_dest_page_sel))
    else $error("copy to wrong page");
  AST_COPY_ENDS: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(st == nvc_pkg::ST_STORE) |-> ##[1:64] st == nvc_pkg::ST_IDLE)
    else $error("copy did not finish");

endmodule

// [hdl/nvc_pkg.sv]
// Constants shared by the nonvolatile control block.
// Assumes a 100 MHz core clock and an 8-bit register address space.
package nvc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTL_STAT = 8'h89;
  localparam logic [7:0] ADDR_LIVE_CRC = 8'h8a;
  localparam logic [7:0] ADDR_PTR_HIGH = 8'h8b;

  // ----------------------------------------------------------------------
  // Control/status field positions
  // ----------------------------------------------------------------------
  localparam int BIT_REGS_TO_SRAM = 6;
  localparam int BIT_CRC_FAIL = 5;
  localparam int BIT_AUTO_CRC = 4;
  localparam int BIT_EE_TO_REGS = 3;
  localparam int BIT_BUSY = 2;
  localparam int BIT_PROG = 0;

  // ----------------------------------------------------------------------
  // Reset values and counter limit
  // ----------------------------------------------------------------------
  localparam logic AUTO_CRC_RST = 1'b1;
  localparam logic [7:0] LIVE_CRC_RST = 8'h00;
  localparam logic [3:0] PTR_HIGH_RST = 4'h0;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  // CRC-8 generator polynomial of the stored configuration image
  localparam logic [7:0] CRC_POLY = 8'h07;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int PROG_TIME_MS = 230;
  localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_FREQ_HZ / 1000);

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LOAD  = 4'b0010,
    ST_STORE = 4'b0100,
    ST_PROG  = 4'b1000
  } nvc_state_t;

endpackage

// [hdl/nvc_prog_timer.sv]
// Erase/program cycle timer.
// Assumes start is a one-cycle pulse issued only while busy is low.
`timescale 1ns/1ps
module nvc_prog_timer #(
  parameter int CYCLES = 23_000_000,
  parameter int CW = 25
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  output logic busy,
  output logic done
);

  logic [CW-1:0] cnt;

  // ----------------------------------------------------------------------
  // Down counter, done pulses in the cycle after the last busy cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        cnt <= CW'(CYCLES - 1);
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end

endmodule

// [verif/nvc_host_model.sv]
// Serial host stand-in driving the register port of the control block.
// Assumes the bench clock; after the time-zero idle levels, every drive is non-blocking at a rising edge.
`timescale 1ns/1ps
module nvc_host_model (
  input wire logic mclk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  output logic txn_end,
  output logic unlock_key_ok
);
  // Idle levels from time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    txn_end = 1'b0;
    unlock_key_ok = 1'b0;
  end

  // One byte written, then the transaction is closed
  task automatic wr_txn(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    txn_end <= 1'b1;
    @(posedge mclk);
    txn_end <= 1'b0;
  endtask

  task automatic unlock_txn;
    @(posedge mclk);
    unlock_key_ok <= 1'b1;
    @(posedge mclk);
    unlock_key_ok <= 1'b0;
    txn_end <= 1'b1;
    @(posedge mclk);
    txn_end <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    repeat (3) begin
      @(posedge mclk);
      if (reg_rd_valid && !ok) begin
        ok = 1'b1;
        d = reg_rdata;
      end
    end
  endtask
endmodule

// [verif/test_nvc_ctrl.sv]
// Self-checking bench for the nonvolatile control block.
// Assumes small array models here and the host model for register access.
`timescale 1ns/1ps
module test_nvc_ctrl;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr, reg_rd, reg_rd_valid, txn_end, unlock_key_ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] mem_ptr_low = 8'h00;
  logic [1:0] sram_dest_page_sel = 2'h0;
  logic aux_clk_active = 1'b1;
  logic [11:0] memory_start_pointer;
  logic [8:0] ee_rd_addr, sram_addr;
  logic ee_rd_en, ee_access_block, ee_prog_start, ee_prog_crc_en;
  logic cfg_wr, sram_wr;
  logic [7:0] ee_rdata;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, sram_wdata, program_cycle_count;
  logic [7:0] ee_mem [16];
  logic [7:0] cfg_mem [16];
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int sram_n = 0;
  int sram_bad = 0;
  int rd_n = 0;

  // ----------------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------------
  always #5 mclk = ~mclk;

  nvc_ctrl #(.NBYTES(16), .PAGES(4), .PROG_CYCLES(20)) u_dut (.mclk(mclk),
    .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .txn_end(txn_end),
    .unlock_key_ok(unlock_key_ok), .mem_ptr_low(mem_ptr_low),
    .sram_dest_page_sel(sram_dest_page_sel),
    .aux_clk_active(aux_clk_active),
    .memory_start_pointer(memory_start_pointer), .ee_rd_addr(ee_rd_addr),
    .ee_rd_en(ee_rd_en), .ee_rdata(ee_rdata),
    .ee_access_block(ee_access_block), .ee_prog_start(ee_prog_start),
    .ee_prog_crc_en(ee_prog_crc_en), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .sram_wr(sram_wr),
    .sram_addr(sram_addr), .sram_wdata(sram_wdata),
    .program_cycle_count(program_cycle_count));

  nvc_host_model u_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .txn_end(txn_end),
    .unlock_key_ok(unlock_key_ok));

  // Array models; the SRAM monitor checks page and data of every write
  // Both arrays answer within the cycle, as the sequencer reads data at
  // the edge after it raises the read enable
  assign cfg_rdata = cfg_mem[cfg_addr[3:0]];
  assign ee_rdata = ee_mem[ee_rd_addr[3:0]];
  always @(posedge mclk) begin
    if (ee_rd_en) rd_n++;
    if (cfg_wr) cfg_mem[cfg_addr[3:0]] <= cfg_wdata;
    if (sram_wr) sram_n++;
    if (sram_wr && (sram_addr[5:4] !== sram_dest_page_sel ||
        sram_wdata !== cfg_mem[sram_addr[3:0]])) sram_bad++;
  end

  // Hang guard well above the longest expected run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] crc8(input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) begin
      c = c ^ ee_mem[i];
      for (int b = 0; b < 8; b++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Optional key, program request, then watch the launch and busy time
  task automatic prog(input logic key, input logic [7:0] v, output int st,
                      output int bz, output logic ce);
    ce = 1'bx;
    if (key) u_host.unlock_txn();
    u_host.wr_txn(8'h89, v);
    st = 0;
    bz = 0;
    // host waits out busy before the next operation
    repeat (40) begin
      @(posedge mclk);
      if (ee_prog_start) ce = ee_prog_crc_en;
      if (ee_prog_start) st++;
      if (ee_access_block) bz++;
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_boot;
    logic [7:0] d;
    logic ok;
    u_host.rd(8'h89, d, ok);
    check(ok, 1'b0);
    repeat (40) @(posedge mclk);
    u_host.rd(8'h89, d, ok);
    check(d, 8'h10);
    u_host.rd(8'h8a, d, ok);
    check(d, crc8(15));
    check(cfg_mem[3], ee_mem[3]);
  endtask

  task automatic t_ptr;
    logic [7:0] d;
    logic ok;
    mem_ptr_low <= 8'h5a;
    u_host.wr_txn(8'h8b, 8'hff);
    u_host.rd(8'h8b, d, ok);
    check(d, 8'h0f);
    check(memory_start_pointer, 12'hf5a);
    u_host.wr_txn(8'h8a, 8'hff);
    u_host.rd(8'h8a, d, ok);
    check(d, crc8(15));
    u_host.rd(8'h8c, d, ok);
    check(d, 8'h00);
  endtask

  task automatic t_copy;
    logic [7:0] d;
    logic ok;
    sram_dest_page_sel <= 2'h2;
    u_host.wr_txn(8'h89, 8'h50);
    repeat (45) @(posedge mclk);
    u_host.rd(8'h89, d, ok);
    check(d, 8'h10);
    check(sram_n > 0, 1'b1);
    check(sram_bad, 12'h000);
  endtask

  task automatic t_commit;
    logic [7:0] d;
    logic ok;
    aux_clk_active <= 1'b0;
    repeat (4) @(posedge mclk);
    ee_mem[15] = ee_mem[15] ^ 8'h01;
    rd_n = 0;
    u_host.wr_txn(8'h89, 8'h18);
    repeat (10) @(posedge mclk);
    check(rd_n, 12'h000);
    aux_clk_active <= 1'b1;
    repeat (50) @(posedge mclk);
    u_host.rd(8'h89, d, ok);
    check(d, 8'h30);
  endtask

  task automatic t_prog;
    logic [7:0] d;
    logic ok, ce;
    int st, bz;
    prog(1'b0, 8'h11, st, bz, ce);
    check(st, 12'h000);
    u_host.unlock_txn();
    u_host.wr_txn(8'h8b, 8'h00);
    prog(1'b0, 8'h11, st, bz, ce);
    check(st, 12'h000);
    prog(1'b1, 8'h11, st, bz, ce);
    check(st, 12'h001);
    check(ce, 1'b1);
    check(bz >= 20 && bz <= 22, 1'b1);
    check(program_cycle_count, 8'h01);
    u_host.unlock_txn();
    u_host.wr_txn(8'h89, 8'h01);
    repeat (3) @(posedge mclk);
    u_host.rd(8'h89, d, ok);
    check(d & 8'h04, 8'h04);
    repeat (40) @(posedge mclk);
    prog(1'b1, 8'h01, st, bz, ce);
    check(ce, 1'b0);
    for (int i = 0; i < 255; i++) prog(1'b1, 8'h11, st, bz, ce);
    check(program_cycle_count, 8'hff);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 16; i++) ee_mem[i] = 8'(8'h13 * i + 8'h05);
    for (int i = 0; i < 16; i++) cfg_mem[i] = 8'h00;
    ee_mem[15] = crc8(15);
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    t_boot();
    t_ptr();
    t_copy();
    t_commit();
    t_prog();
    complete_run();
  end
endmodule
